// [inc/core_pkg.sv]
// Shared constants and types for the 8-bit core datapath
package core_pkg;
   // Program counter width and reset value (all ones, wraps to zero)
   localparam int PC_W_DEF = 9;
   localparam int JUMP_W = 9;
   localparam int INSTR_W = 12;
   localparam int DATA_W = 8;
   // Oscillator clocks per instruction cycle
   localparam int CLK_PER_INSTR = 4;
   localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;
   localparam logic [INSTR_W-1:0] TRIS_WORD = 12'h006;
   // Register file addresses held inside the core
   localparam logic [4:0] ADDR_PCL = 5'h02;
   localparam logic [4:0] ADDR_STATUS = 5'h03;
   localparam logic [4:0] ADDR_GPIO = 5'h06;
   // Status flag positions and reset value
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam logic [2:0] FLAGS_RST = 3'h0;
   localparam logic [2:0] TRIS_RST = 3'h7;
   // File operations, instruction bits 11:6
   localparam logic [5:0] OP_MOVWF = 6'h00;
   localparam logic [5:0] OP_CLR = 6'h01;
   localparam logic [5:0] OP_SUB = 6'h02;
   localparam logic [5:0] OP_DEC = 6'h03;
   localparam logic [5:0] OP_OR = 6'h04;
   localparam logic [5:0] OP_AND = 6'h05;
   localparam logic [5:0] OP_XOR = 6'h06;
   localparam logic [5:0] OP_ADD = 6'h07;
   localparam logic [5:0] OP_MOV = 6'h08;
   localparam logic [5:0] OP_COM = 6'h09;
   localparam logic [5:0] OP_INC = 6'h0a;
   localparam logic [5:0] OP_RR = 6'h0c;
   localparam logic [5:0] OP_RL = 6'h0d;
   // Literal operations, instruction bits 11:8
   localparam logic [3:0] LIT_MOV = 4'hc;
   localparam logic [3:0] LIT_OR = 4'hd;
   localparam logic [3:0] LIT_AND = 4'he;
   localparam logic [3:0] LIT_XOR = 4'hf;
   localparam logic [2:0] JUMP_CODE = 3'h5;
   // Pin synchroniser layout: pins 0..3 then high-voltage detect
   localparam int SYNC_W = 5;
   localparam int SYNC_HV = 4;
   localparam logic [SYNC_W-1:0] SYNC_RST = 5'h08;
   typedef enum logic [1:0] {
      PH_ONE = 2'b00,
      PH_TWO = 2'b01,
      PH_THREE = 2'b11,
      PH_FOUR = 2'b10
   } phase_e;
   typedef struct packed {
      logic [4:0] addr;
      logic [DATA_W-1:0] wdata;
      logic we;
   } data_req_s;
   typedef struct packed {
      logic [2:0] out;
      logic [2:0] oe;
   } pin_drive_s;
endpackage : core_pkg

// [verification/core_mem_model.sv]
// Program memory and data register file model for the core datapath
`timescale 1ns/10ps
`default_nettype none
module core_mem_model
   import core_pkg::*;
#(
   parameter int PC_W = PC_W_DEF
)
(
   input wire logic clock, // Instruction clock source
   input wire logic [PC_W-1:0] prog_addr, // Program bus address
   output logic [INSTR_W-1:0] prog_data, // Program bus word
   input wire data_req_s dreq, // Data bus request
   output logic [DATA_W-1:0] data_rdata // Data bus read word
);
   logic [INSTR_W-1:0] prog_mem [0:(1<<PC_W)-1];
   logic [DATA_W-1:0] file_mem [0:31];

   // Whole 12-bit words on their own bus, read without wait states
   assign prog_data = prog_mem[prog_addr];
   // Byte-wide file read; core-held addresses are answered inside the core
   assign data_rdata = file_mem[dreq.addr];

   // Destination write lands on the strobe edge only
   always_ff @(posedge clock)
   begin
      if (dreq.we)
         file_mem[dreq.addr] <= dreq.wdata;
   end
endmodule : core_mem_model
`default_nettype wire

// [verification/eight_bit_risc_core_datapath_tb_top.sv]
// Self-checking bench for the 8-bit core datapath
`timescale 1ns/10ps
`default_nettype none
module eight_bit_risc_core_datapath_tb_top;
   import core_pkg::*;
   typedef struct {
      logic [4:0] addr;
      logic [7:0] data;
      logic [2:0] flg;
      int gap;
   } exp_s;
   logic clock = 1'b0;
   logic rst_n, hv_detect, ext_reset_en, wake_r, phase_two_r, phase_four_r, prog_mode_r;
   logic [8:0] prog_addr_r;
   logic [11:0] prog_data, prog_word_r;
   logic [7:0] data_rdata, acc;
   logic [3:0] pin_in;
   logic [2:0] pullup_en, wake_en, pullup_on_r, flags_r, fl;
   logic [31:0] seed = 32'h4f3d27dd;
   data_req_s dreq;
   pin_drive_s pin_drv_r;
   exp_s expq [$];
   exp_s sb_e;
   int n_errors = 0;
   int n_tests = 0;
   int pc, icnt, cyc, lastc, cnt, k;
   int last = -1;

   always #5 clock = ~clock;

   risc_core_datapath #(.PC_W(9)) uut (.clock(clock), .rst_n(rst_n),
      .prog_addr_r(prog_addr_r), .prog_data(prog_data), .dreq_r(dreq),
      .data_rdata(data_rdata), .pin_in(pin_in), .pin_drv_r(pin_drv_r),
      .hv_detect(hv_detect), .ext_reset_en(ext_reset_en), .pullup_en(pullup_en),
      .wake_en(wake_en), .pullup_on_r(pullup_on_r), .wake_r(wake_r), .flags_r(flags_r),
      .phase_two_r(phase_two_r), .phase_four_r(phase_four_r), .prog_mode_r(prog_mode_r),
      .prog_word_r(prog_word_r));

   core_mem_model #(.PC_W(9)) mem (.clock(clock), .prog_addr(prog_addr_r),
      .prog_data(prog_data), .dreq(dreq), .data_rdata(data_rdata));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // Place one word; c is the instruction cycles it costs (0 for a flushed word)
   task automatic put(input logic [11:0] w, input int c);
      mem.prog_mem[pc] = w;
      pc++;
      icnt += c;
   endtask : put

   // Store accumulator to a file; core-held addresses raise no strobe
   task automatic wr(input logic [4:0] a);
      if (a == ADDR_STATUS)
         fl = acc[2:0];
      if (a != ADDR_STATUS && a != ADDR_PCL && a != ADDR_GPIO)
      begin
         expq.push_back('{a, acc, fl, (last < 0) ? 0 : 4 * (icnt - last)});
         last = icnt;
      end
      put({OP_MOVWF, 1'b1, a}, (a == ADDR_PCL) ? 2 : 1);
   endtask : wr

   // Reference ALU; acc is the second operand, f the file or literal value
   task automatic calc(input logic [5:0] op, input logic [7:0] f);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] r;
      logic [2:0] n;
      n = fl;
      s = {1'b0, f} + {1'b0, acc};
      h = {1'b0, f[3:0]} + {1'b0, acc[3:0]};
      if (op == OP_SUB)
      begin
         s = {1'b0, f} + {1'b0, ~acc} + 9'h001;
         h = {1'b0, f[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
      end
      case (op)
         OP_ADD, OP_SUB: {r, n[1:0]} = {s[7:0], h[4], s[8]};
         OP_OR: r = f | acc;
         OP_AND: r = f & acc;
         OP_XOR: r = f ^ acc;
         OP_COM: r = ~f;
         OP_INC: r = f + 8'h01;
         OP_DEC: r = f - 8'h01;
         OP_RR: {r, n[0]} = {fl[0], f};
         OP_RL: {n[0], r} = {f, fl[0]};
         OP_CLR: r = 8'h00;
         default: r = f;
      endcase
      if (op != OP_RR && op != OP_RL)
         n[2] = (r == 8'h00);
      acc = r;
      fl = n;
   endtask : calc

   // Straight-line program: operand groups, status store, two kinds of branch
   task automatic build;
      logic [5:0] ops [12] = '{OP_ADD, OP_SUB, OP_OR, OP_AND, OP_XOR, OP_COM, OP_INC,
         OP_DEC, OP_RR, OP_RL, OP_CLR, OP_MOV};
      logic [7:0] a, b;
      fl = FLAGS_RST;
      for (int i = 0; i < 512; i++)
         mem.prog_mem[i] = NOP_WORD;
      mem.prog_mem[511] = {JUMP_CODE, 9'h000};
      for (int p = 0; p < 2; p++)
         for (int i = 0; i < 15; i++)
         begin
            seed = lfsr_next(seed);
            a = p ? seed[7:0] : 8'h80;
            b = p ? seed[15:8] : 8'h80;
            acc = a;
            put({LIT_MOV, a}, 1);
            wr(5'h10);
            if (i < 12)
            begin
               acc = b;
               put({LIT_MOV, b}, 1);
               put({ops[i], 1'b0, 5'h10}, 1);
               calc(ops[i], a);
            end
            else
            begin
               put({LIT_OR + 4'(i - 12), b}, 1);
               calc(ops[i - 10], b);
            end
            wr(5'h11);
         end
      acc = 8'h05;
      put({LIT_MOV, acc}, 1);
      wr(ADDR_STATUS);
      wr(5'h15);
      // Direction from the accumulator, then the port latch through its address
      acc = 8'h02;
      put({LIT_MOV, acc}, 1);
      put(TRIS_WORD, 1);
      acc = 8'h05;
      put({LIT_MOV, acc}, 1);
      wr(ADDR_GPIO);
      acc = 8'he0;
      put({LIT_MOV, acc}, 1);
      wr(ADDR_PCL);
      put({OP_MOVWF, 1'b1, 5'h12}, 0);
      pc = 'he0;
      acc = 8'h5a;
      put({LIT_MOV, acc}, 1);
      wr(5'h13);
      put({JUMP_CODE, 9'h0f0}, 2);
      put({OP_MOVWF, 1'b1, 5'h12}, 0);
      pc = 'hf0;
      wr(5'h14);
      put({JUMP_CODE, 9'h0f1}, 2);
   endtask : build

   // Each write strobe is matched with the oldest noted write and its spacing
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (rst_n === 1'b1 && dreq.we === 1'b1)
      begin
         if (expq.size() == 0)
            chk("stray_write", 16'hffff, 16'(dreq.addr));
         else
         begin
            sb_e = expq.pop_front();
            chk("wr_addr", 16'(sb_e.addr), 16'(dreq.addr));
            chk("wr_data", 16'(sb_e.data), 16'(dreq.wdata));
            chk("flags", 16'(sb_e.flg), 16'(flags_r));
            chk("wr_phase", 16'h1, 16'({phase_two_r, phase_four_r}));
            if (sb_e.gap != 0)
               chk("gap", 16'(sb_e.gap), 16'(cyc - lastc));
            lastc = cyc;
         end
      end
   end

   // Main sequence; the pin stimulus stands in for the board around the part
   initial
   begin
      rst_n = 1'b0;
      hv_detect = 1'b0;
      ext_reset_en = 1'b0;
      pin_in = 4'h8;
      pullup_en = 3'h0;
      wake_en = 3'h0;
      build();
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      for (k = 0; k < 4000 && expq.size() > 0; k++)
         @(posedge clock);
      if (expq.size() > 0)
      begin
         n_errors++;
         $display("CHECK FAILED program expected drained seen %0d left", expq.size());
         stop_test();
      end
      repeat (40) @(posedge clock);
      // Latch 101b driven out, direction 010b leaves pin one as input
      chk("pin_drv", 16'h002d, 16'(pin_drv_r));
      $display("test alu_program done");
      // Pull-ups follow their enables, pin 3 forced while it is the reset input
      for (int i = 0; i < 16; i++)
      begin
         seed = lfsr_next(seed);
         @(posedge clock);
         pullup_en <= seed[2:0];
         ext_reset_en <= seed[3];
         repeat (3) @(posedge clock);
         #1;
         chk("pullup", {13'h0, seed[3] | seed[2], seed[1:0]}, 16'(pullup_on_r));
      end
      $display("test pullups done");
      // Toggle pins 0, 1, 3 with wake enabled, then again with it disabled
      for (int b = 0; b < 6; b++)
      begin
         @(posedge clock);
         ext_reset_en <= 1'b0;
         wake_en <= (b < 3) ? 3'(3'h1 << b) : 3'h0;
         pin_in <= pin_in ^ ((b % 3 == 2) ? 4'h8 : 4'(4'h1 << (b % 3)));
         cnt = 0;
         repeat (10)
         begin
            @(posedge clock);
            #1;
            cnt += int'(wake_r);
         end
         chk("wake", (b < 3) ? 16'h1 : 16'h0, 16'(cnt));
      end
      $display("test wake done");
      // Reset pin low keeps the core parked at the top address
      @(posedge clock);
      ext_reset_en <= 1'b1;
      pin_in[3] <= 1'b0;
      repeat (8) @(posedge clock);
      for (int i = 0; i < 3; i++)
      begin
         repeat (3) @(posedge clock);
         #1;
         chk("held_addr", 16'h01ff, 16'(prog_addr_r));
      end
      $display("test reset_pin done");
      // Above-supply level enters programming, then one word is shifted in
      @(posedge clock);
      hv_detect <= 1'b1;
      for (k = 0; k < 20 && prog_mode_r !== 1'b1; k++)
      begin
         @(posedge clock);
         #1;
      end
      chk("prog_mode", 16'h1, 16'(prog_mode_r));
      chk("pin_oe", 16'h0, 16'(pin_drv_r.oe));
      @(posedge clock);
      pin_in[3] <= 1'b1;
      seed = lfsr_next(seed);
      for (int i = 0; i < 12; i++)
      begin
         @(posedge clock);
         pin_in[0] <= seed[i];
         repeat (6) @(posedge clock);
         pin_in[1] <= 1'b1;
         repeat (6) @(posedge clock);
         pin_in[1] <= 1'b0;
      end
      repeat (8) @(posedge clock);
      #1;
      chk("prog_word", 16'(seed[11:0]), 16'(prog_word_r));
      $display("test programming done");
      stop_test();
   end
endmodule : eight_bit_risc_core_datapath_tb_top
`default_nettype wire

// [verilog/risc_core_datapath.sv]
// Fetch/execute datapath, ALU, pins and programming entry of the 8-bit core
// Behaviour
// - Every instruction is one 12-bit word.
// - One whole instruction is fetched per instruction cycle on its own bus.
// - Data words are 8 bits on a bus apart from the instruction bus.
// - Fetch of the next instruction overlaps execution of the current one.
// - Each instruction completes in one instruction cycle, branches excepted.
// - Program counter changes take two cycles; the fetched word is discarded.
// - Clock is divided by four into four phases forming one cycle.
// - Operand is read in phase two, destination written in phase four.
// - Special registers, program counter included, sit in data address space.
// - Eight-bit ALU adds, subtracts, shifts and does logic.
// - Arithmetic is two's complement.
// - Two-operand ops use accumulator and a file register or literal.
// - Single-operand ops use accumulator or a file register.
// - Eight-bit accumulator, not reachable at any data address.
// - Carry, nibble carry, zero updated per instruction, else kept.
// - Subtraction carries mean no borrow when set.
// - Pins zero and one have enabled pull-up and wake on change.
// - Input-only pin has enabled pull-up and wake on change.
// - Input-only pin as external reset holds the core while low.
// - Pull-up forced on while input-only pin is the reset input.
// - Pin above supply enters programming mode; the far side keeps it low.
// - Programming mode takes serial clock on pin one.
// - Programming data travels on pin zero beside the clock.
`timescale 1ns/10ps
`default_nettype none
module risc_core_datapath
   import core_pkg::*;
#(
   parameter int PC_W = PC_W_DEF
)
(
   input wire logic clock, // Instruction clock source
   input wire logic rst_n, // Synchronous reset, active low
   output logic [PC_W-1:0] prog_addr_r, // Program bus address
   input wire logic [INSTR_W-1:0] prog_data, // Program bus word
   output data_req_s dreq_r, // Data bus address, write data, strobe
   input wire logic [DATA_W-1:0] data_rdata, // Data bus read word
   input wire logic [3:0] pin_in, // Pin levels, pin 3 input only
   output pin_drive_s pin_drv_r, // Drive and enable for pins 0..2
   input wire logic hv_detect, // Input-only pin above supply
   input wire logic ext_reset_en, // Input-only pin serves as reset
   input wire logic [2:0] pullup_en, // Pull-up enables, pins 0,1,3
   input wire logic [2:0] wake_en, // Wake enables, pins 0,1,3
   output logic [2:0] pullup_on_r, // Pull-ups on, pins 0,1,3
   output logic wake_r, // Pin change wake pulse
   output logic [2:0] flags_r, // Zero, nibble carry, carry
   output logic phase_two_r, // High during phase two
   output logic phase_four_r, // High during phase four
   output logic prog_mode_r, // Programming mode
   output logic [INSTR_W-1:0] prog_word_r // Serially received word
);

   // Jump targets and PCL writes must fit the counter
   if (PC_W < JUMP_W || PC_W > 16)
   begin : g_pc_check
      $error("PC_W out of range");
   end

   logic [SYNC_W-1:0] s1_r, s2_r, s3_r, filt_r;
   logic core_rst;
   phase_e ph_r, ph_nxt;
   logic [PC_W-1:0] pc_r;
   logic [INSTR_W-1:0] ir_r;
   logic [DATA_W-1:0] acc_r, opnd_r, rd_val, res;
   logic [2:0] gpio_lat_r, tris_r, fmask, pin_prev_r;
   logic [2:0] pin_now;
   logic clk_prev_r, prog_clk_rise;
   logic bidir_pin_zero, bidir_pin_one, input_only_pin;
   logic external_reset_pin, prog_serial_clock, prog_serial_data;
   logic is_lit, is_jump, is_fop, is_tris, d_bit, take_br;
   logic wacc, wfile, cy, dcy;
   logic [5:0] fop;
   logic [4:0] faddr;
   logic [DATA_W-1:0] lit, ax;
   logic ci;
   logic [DATA_W:0] s9;
   logic [4:0] s5;

   // True for addresses served inside the core, not by the file
   function automatic logic is_internal(input logic [4:0] a);
      is_internal = (a == ADDR_PCL) || (a == ADDR_STATUS) || (a == ADDR_GPIO);
   endfunction : is_internal

   // Three-stage pin synchroniser; a level counts once stages two and three agree
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s1_r <= SYNC_RST;
         s2_r <= SYNC_RST;
         s3_r <= SYNC_RST;
         filt_r <= SYNC_RST;
      end
      else
      begin
         s1_r <= {hv_detect, pin_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < SYNC_W; i++)
         begin
            if (s2_r[i] == s3_r[i])
            begin
               filt_r[i] <= s3_r[i];
            end
         end
      end
   end

   assign bidir_pin_zero = filt_r[0];
   assign bidir_pin_one = filt_r[1];
   assign input_only_pin = filt_r[3];
   assign external_reset_pin = input_only_pin;
   assign prog_serial_clock = bidir_pin_one;
   assign prog_serial_data = bidir_pin_zero;
   assign pin_now = {input_only_pin, bidir_pin_one, bidir_pin_zero};

   // Core held in reset by the bus reset, programming mode or the reset pin
   assign core_rst = !rst_n || prog_mode_r || (ext_reset_en && !external_reset_pin);

   // Programming entry follows the filtered high-voltage detect
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         prog_mode_r <= 1'b0;
      end
      else
      begin
         prog_mode_r <= filt_r[SYNC_HV];
      end
   end

   // Serial word shifter, LSB first, on rising programming clock
   assign prog_clk_rise = prog_serial_clock && !clk_prev_r;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         clk_prev_r <= 1'b0;
         prog_word_r <= NOP_WORD;
      end
      else
      begin
         clk_prev_r <= prog_serial_clock;
         if (prog_mode_r && prog_clk_rise)
         begin
            prog_word_r <= {prog_serial_data, prog_word_r[INSTR_W-1:1]};
         end
      end
   end

   // Pull-ups; the reset pin keeps its pull-up whatever software asks
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pullup_on_r <= 3'h0;
      end
      else
      begin
         pullup_on_r <= {pullup_en[2] || ext_reset_en, pullup_en[1:0]};
      end
   end

   // Pin change wake; the reset pin cannot wake since low means reset
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pin_prev_r <= {SYNC_RST[3], SYNC_RST[1:0]}; // Idle levels, so no false change after reset
         wake_r <= 1'b0;
      end
      else
      begin
         pin_prev_r <= pin_now;
         wake_r <= |(wake_en & (pin_now ^ pin_prev_r) & {!ext_reset_en, 2'b11});
      end
   end

   // Four-phase sequencer from the divided clock
   always_comb
   begin
      case (ph_r)
         PH_ONE: ph_nxt = PH_TWO;
         PH_TWO: ph_nxt = PH_THREE;
         PH_THREE: ph_nxt = PH_FOUR;
         PH_FOUR: ph_nxt = PH_ONE;
         default: ph_nxt = PH_ONE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (core_rst)
      begin
         ph_r <= PH_ONE;
         phase_two_r <= 1'b0;
         phase_four_r <= 1'b0;
      end
      else
      begin
         ph_r <= ph_nxt;
         phase_two_r <= (ph_nxt == PH_TWO);
         phase_four_r <= (ph_nxt == PH_FOUR);
      end
   end

   // Instruction field decode
   assign fop = ir_r[11:6];
   assign d_bit = ir_r[5];
   assign faddr = ir_r[4:0];
   assign lit = ir_r[7:0];
   assign is_lit = (ir_r[11:10] == 2'b11);
   assign is_jump = (ir_r[11:9] == JUMP_CODE);
   assign is_fop = (ir_r[11:10] == 2'b00);
   assign is_tris = (ir_r == TRIS_WORD);

   // Operand read mux; the accumulator has no address here
   always_comb
   begin
      case (dreq_r.addr)
         ADDR_PCL: rd_val = pc_r[DATA_W-1:0];
         ADDR_STATUS: rd_val = {5'h00, flags_r};
         ADDR_GPIO: rd_val = {4'h0, filt_r[3:0]};
         default: rd_val = data_rdata;
      endcase
   end

   // Shared adder: subtraction adds the inverted accumulator plus one
   assign ci = is_fop && (fop == OP_SUB);
   assign ax = ci ? ~acc_r : acc_r;
   assign s9 = {1'b0, opnd_r} + {1'b0, ax} + {8'h00, ci};
   assign s5 = {1'b0, opnd_r[3:0]} + {1'b0, ax[3:0]} + {4'h0, ci};

   // ALU result, destination and flag mask
   always_comb
   begin
      res = acc_r;
      cy = s9[DATA_W];
      dcy = s5[4];
      fmask = 3'h0;
      wacc = 1'b0;
      wfile = 1'b0;
      if (is_lit)
      begin
         wacc = 1'b1;
         fmask = 3'h4;
         case (ir_r[11:8])
            LIT_OR: res = acc_r | lit;
            LIT_AND: res = acc_r & lit;
            LIT_XOR: res = acc_r ^ lit;
            default:
            begin
               res = lit;
               fmask = 3'h0;
            end
         endcase
      end
      else if (is_fop)
      begin
         wacc = !d_bit;
         wfile = d_bit;
         case (fop)
            OP_ADD, OP_SUB:
            begin
               res = s9[DATA_W-1:0];
               fmask = 3'h7;
            end
            OP_AND:
            begin
               res = acc_r & opnd_r;
               fmask = 3'h4;
            end
            OP_OR:
            begin
               res = acc_r | opnd_r;
               fmask = 3'h4;
            end
            OP_XOR:
            begin
               res = acc_r ^ opnd_r;
               fmask = 3'h4;
            end
            OP_COM:
            begin
               res = ~opnd_r;
               fmask = 3'h4;
            end
            OP_INC:
            begin
               res = opnd_r + 8'h01;
               fmask = 3'h4;
            end
            OP_DEC:
            begin
               res = opnd_r - 8'h01;
               fmask = 3'h4;
            end
            OP_MOV:
            begin
               res = opnd_r;
               fmask = 3'h4;
            end
            OP_CLR:
            begin
               res = 8'h00;
               fmask = 3'h4;
            end
            OP_RR:
            begin
               res = {flags_r[FLAG_C], opnd_r[7:1]};
               cy = opnd_r[0];
               fmask = 3'h1;
            end
            OP_RL:
            begin
               res = {opnd_r[6:0], flags_r[FLAG_C]};
               cy = opnd_r[7];
               fmask = 3'h1;
            end
            OP_MOVWF:
            begin
               res = acc_r;
               wacc = 1'b0;
            end
            default:
            begin
               wacc = 1'b0;
               wfile = 1'b0;
            end
         endcase
      end
   end

   // A jump or a write to the counter low byte redirects the fetch
   assign take_br = is_jump || (wfile && faddr == ADDR_PCL);

   // Data bus: address in phase one, operand taken in phase two, strobe in phase four
   always_ff @(posedge clock)
   begin
      if (core_rst)
      begin
         dreq_r <= '0;
         opnd_r <= 8'h00;
      end
      else
      begin
         if (ph_r == PH_ONE)
         begin
            dreq_r.addr <= faddr;
         end
         if (ph_r == PH_TWO)
         begin
            opnd_r <= rd_val;
         end
         dreq_r.wdata <= res;
         dreq_r.we <= (ph_r == PH_THREE) && wfile && !is_internal(faddr);
      end
   end

   // Program counter and instruction register; next fetch overlaps execution
   always_ff @(posedge clock)
   begin
      if (core_rst)
      begin
         pc_r <= '1;
         prog_addr_r <= '1;
         ir_r <= NOP_WORD;
      end
      else if (ph_r == PH_ONE)
      begin
         prog_addr_r <= pc_r;
         pc_r <= pc_r + 1'b1;
      end
      else if (ph_r == PH_FOUR)
      begin
         if (is_jump)
         begin
            pc_r <= PC_W'(ir_r[JUMP_W-1:0]);
         end
         else if (take_br)
         begin
            pc_r <= PC_W'(res);
         end
         ir_r <= take_br ? NOP_WORD : prog_data;
      end
   end

   // Accumulator, written only by instructions naming it
   always_ff @(posedge clock)
   begin
      if (core_rst)
      begin
         acc_r <= 8'h00;
      end
      else if (ph_r == PH_FOUR && wacc)
      begin
         acc_r <= res;
      end
   end

   // Flags: instruction-driven updates win over a software write to status
   always_ff @(posedge clock)
   begin
      if (core_rst)
      begin
         flags_r <= FLAGS_RST;
      end
      else if (ph_r == PH_FOUR)
      begin
         if (wfile && faddr == ADDR_STATUS)
         begin
            flags_r <= res[2:0];
         end
         if (fmask[FLAG_C])
         begin
            flags_r[FLAG_C] <= cy;
         end
         if (fmask[FLAG_DC])
         begin
            flags_r[FLAG_DC] <= dcy;
         end
         if (fmask[FLAG_Z])
         begin
            flags_r[FLAG_Z] <= (res == 8'h00);
         end
      end
   end

   // Port latch and direction; all pins float in reset or programming
   always_ff @(posedge clock)
   begin
      if (core_rst)
      begin
         gpio_lat_r <= 3'h0;
         tris_r <= TRIS_RST;
         pin_drv_r <= '0;
      end
      else
      begin
         if (ph_r == PH_FOUR && wfile && faddr == ADDR_GPIO)
         begin
            gpio_lat_r <= res[2:0];
         end
         if (ph_r == PH_FOUR && is_tris)
         begin
            tris_r <= acc_r[2:0];
         end
         pin_drv_r.out <= gpio_lat_r;
         pin_drv_r.oe <= ~tris_r;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (core_rst);

   phase_order_a: assert property (ph_r == PH_ONE |=> ph_r == PH_TWO ##1 ph_r == PH_THREE ##1 ph_r == PH_FOUR ##1 ph_r == PH_ONE)
      else $error("phase order broken");
   pc_step_a: assert property (ph_r == PH_ONE |=> pc_r == $past(pc_r) + 1'b1)
      else $error("counter did not step in phase one");
   fetch_hold_a: assert property (ph_r == PH_TWO |=> $stable(prog_addr_r) [*3])
      else $error("fetch address moved within cycle");
   branch_flush_a: assert property (ph_r == PH_FOUR && take_br |=> ir_r == NOP_WORD)
      else $error("fetched word not discarded");
   fetch_load_a: assert property (ph_r == PH_FOUR && !take_br |=> ir_r == $past(prog_data))
      else $error("fetched word not loaded");
   write_phase_a: assert property (dreq_r.we |-> ph_r == PH_FOUR)
      else $error("write strobe outside phase four");
   read_addr_a: assert property (ph_r == PH_TWO |-> dreq_r.addr == ir_r[4:0])
      else $error("operand address wrong in phase two");
   sub_carry_a: assert property (ph_r == PH_FOUR && is_fop && fop == OP_SUB && opnd_r >= acc_r |=> flags_r[FLAG_C])
      else $error("no-borrow carry not set");
   zero_flag_a: assert property (ph_r == PH_FOUR && fmask[FLAG_Z] |=> flags_r[FLAG_Z] == ($past(res) == 8'h00))
      else $error("zero flag wrong");
   flags_kept_a: assert property (ph_r == PH_FOUR && fmask == 3'h0 && !(wfile && faddr == ADDR_STATUS) |=> $stable(flags_r))
      else $error("flags changed by unaffected op");
   ext_reset_a: assert property (@(posedge clock) disable iff (!rst_n) ext_reset_en && !filt_r[3] |=> ph_r == PH_ONE && pc_r == '1)
      else $error("reset pin did not hold core");
   reset_pullup_a: assert property (@(posedge clock) disable iff (!rst_n) ext_reset_en |=> pullup_on_r[2])
      else $error("reset pin pull-up off");
   prog_entry_a: assert property (@(posedge clock) disable iff (!rst_n) filt_r[SYNC_HV] |=> prog_mode_r ##1 pin_drv_r.oe == 3'h0)
      else $error("programming mode not entered");

   branch_c: cover property (ph_r == PH_FOUR && is_jump);
   subtract_c: cover property (ph_r == PH_FOUR && is_fop && fop == OP_SUB);
   wake_c: cover property (@(posedge clock) disable iff (!rst_n) wake_r);
   serial_c: cover property (@(posedge clock) disable iff (!rst_n) prog_mode_r && prog_clk_rise);

endmodule : risc_core_datapath
`default_nettype wire
